// ===== rtl/isc_pkg.sv
/*
  Constants for the input scaling, calculate and frequency offset register bank.
  Assumes an APB master with 32-bit data; registers sit at word index times four.
*/
package isc_pkg;

  // ==========================================================================
  // Register indices (byte address is four times the index)
  localparam logic [15:0] ISC_CUR_START_FREQ_IDX = 16'h1080;
  localparam logic [15:0] ISC_CUR_END_FREQ_IDX   = 16'h1082;
  localparam logic [15:0] ISC_CUR_START_PCT_IDX  = 16'h1083;
  localparam logic [15:0] ISC_CUR_END_PCT_IDX    = 16'h1084;
  localparam logic [15:0] ISC_CUR_START_SEL_IDX  = 16'h1085;
  localparam logic [15:0] ISC_OPA_SRC_IDX        = 16'h108E;
  localparam logic [15:0] ISC_OPB_SRC_IDX        = 16'h108F;
  localparam logic [15:0] ISC_OPERATOR_IDX       = 16'h1090;
  localparam logic [15:0] ISC_OFS_VALUE_IDX      = 16'h1091;
  localparam logic [15:0] ISC_OFS_SIGN_IDX       = 16'h1093;
  localparam logic [15:0] ISC_POT_START_FREQ_IDX = 16'h1095;
  localparam logic [15:0] ISC_POT_END_FREQ_IDX   = 16'h1097;
  localparam logic [15:0] ISC_POT_START_PCT_IDX  = 16'h1098;
  localparam logic [15:0] ISC_POT_END_PCT_IDX    = 16'h1099;
  localparam logic [15:0] ISC_POT_START_EN_IDX   = 16'h109A;
  localparam logic [15:0] ISC_STAT_CALC_IDX      = 16'h10F0;
  localparam logic [15:0] ISC_STAT_FREQ_IDX      = 16'h10F1;

  // ==========================================================================
  // Ranges and reset values
  localparam logic [15:0] ISC_FREQ_MAX  = 16'h0FA0;
  localparam logic [15:0] ISC_PCT_MAX   = 16'h0064;
  localparam logic [15:0] ISC_BIT_MAX   = 16'h0001;
  localparam logic [15:0] ISC_SRC_MAX   = 16'h0004;
  localparam logic [15:0] ISC_OP_MAX    = 16'h0002;
  localparam logic [15:0] ISC_RST_ZERO  = 16'h0000;
  localparam int          ISC_STAT_OFS_ACTIVE_BIT = 16;

  // ==========================================================================
  // Slot table of the writable registers
  localparam int ISC_NREG = 15;
  localparam int ISC_S_CUR_SF = 0;
  localparam int ISC_S_CUR_EF = 1;
  localparam int ISC_S_CUR_SP = 2;
  localparam int ISC_S_CUR_EP = 3;
  localparam int ISC_S_CUR_SEL = 4;
  localparam int ISC_S_OPA = 5;
  localparam int ISC_S_OPB = 6;
  localparam int ISC_S_OPER = 7;
  localparam int ISC_S_OFS = 8;
  localparam int ISC_S_SIGN = 9;
  localparam int ISC_S_POT_SF = 10;
  localparam int ISC_S_POT_EF = 11;
  localparam int ISC_S_POT_SP = 12;
  localparam int ISC_S_POT_EP = 13;
  localparam int ISC_S_POT_EN = 14;

  localparam logic [15:0] ISC_IDX_TAB [ISC_NREG] = '{
    ISC_CUR_START_FREQ_IDX, ISC_CUR_END_FREQ_IDX, ISC_CUR_START_PCT_IDX,
    ISC_CUR_END_PCT_IDX, ISC_CUR_START_SEL_IDX, ISC_OPA_SRC_IDX, ISC_OPB_SRC_IDX,
    ISC_OPERATOR_IDX, ISC_OFS_VALUE_IDX, ISC_OFS_SIGN_IDX, ISC_POT_START_FREQ_IDX,
    ISC_POT_END_FREQ_IDX, ISC_POT_START_PCT_IDX, ISC_POT_END_PCT_IDX,
    ISC_POT_START_EN_IDX};
  localparam logic [15:0] ISC_MAX_TAB [ISC_NREG] = '{
    ISC_FREQ_MAX, ISC_FREQ_MAX, ISC_PCT_MAX, ISC_PCT_MAX, ISC_BIT_MAX,
    ISC_SRC_MAX, ISC_SRC_MAX, ISC_OP_MAX, ISC_FREQ_MAX, ISC_BIT_MAX,
    ISC_FREQ_MAX, ISC_FREQ_MAX, ISC_PCT_MAX, ISC_PCT_MAX, ISC_BIT_MAX};
  localparam logic [15:0] ISC_RST_TAB [ISC_NREG] = '{
    ISC_RST_ZERO, ISC_FREQ_MAX, ISC_RST_ZERO, ISC_PCT_MAX, ISC_RST_ZERO,
    ISC_RST_ZERO, ISC_RST_ZERO, ISC_RST_ZERO, ISC_RST_ZERO, ISC_RST_ZERO,
    ISC_RST_ZERO, ISC_FREQ_MAX, ISC_RST_ZERO, ISC_PCT_MAX, ISC_RST_ZERO};

  // ==========================================================================
  // Codes
  localparam logic [15:0] ISC_SRC_DIGITAL = 16'h0000;
  localparam logic [15:0] ISC_SRC_POT     = 16'h0001;
  localparam logic [15:0] ISC_SRC_VOLT    = 16'h0002;
  localparam logic [15:0] ISC_SRC_CURRENT = 16'h0003;
  localparam logic [15:0] ISC_SRC_NETWORK = 16'h0004;
  localparam logic [15:0] ISC_OPER_ADD    = 16'h0000;
  localparam logic [15:0] ISC_OPER_SUB    = 16'h0001;
  localparam logic [15:0] ISC_OPER_MUL    = 16'h0002;
  localparam logic [15:0] ISC_SIGN_PLUS   = 16'h0000;
  localparam logic [15:0] ISC_CUR_SEL_CFG = 16'h0000;
  localparam logic [15:0] ISC_POT_EN_ON   = 16'h0001;

endpackage : isc_pkg

// ===== rtl/isc_bank.sv
/*
  Register bank and datapath for input scaling, the two-operand calculate
  function and the terminal-triggered frequency offset, reached over APB.
  Assumes all inputs except the offset-request terminal come from logic on MCLK.
*/
// Our own choice: the APB interface to the registers.
`timescale 1ns/1ps

// Summary of operation
// - Hold current-input range start point, 0 to 100 percent.
// - Hold current-input range end point, 0 to 100 percent.
// - Below current start: code 00 gives start frequency, 01 gives 0 Hz.
// - Operand A source: digital, potentiometer, voltage, current, network; 0 to 4.
// - Operand B source uses same five codes, independent of A.
// - Operator 00 adds, 01 subtracts, 02 multiplies the operands.
// - Offset request terminal active applies stored offset, 0 to 4000.
// - Offset sign 00 adds, 01 subtracts the offset.
// - Hold potentiometer start frequency, 0 to 4000 in 0.1 Hz.
// - Hold potentiometer end frequency, 0 to 4000 in 0.1 Hz.
// - Hold potentiometer range start point, 0 to 100 percent.
// - Hold potentiometer range end point, 0 to 100 percent.
// - Potentiometer start enable accepts only 00 disabled, 01 enabled.
// - Hold current-input start frequency, 0 to 4000 in 0.1 Hz.
module isc_bank
  import isc_pkg::*;
(
  // Clock and reset
  input  wire logic        MCLK,
  input  wire logic        SYS_RST,
  // APB slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [15:0] PADDR,
  input  wire logic [31:0] PWDATA,
  input  wire logic [3:0]  PSTRB,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // Reference sources, 0.1 Hz units or percent
  input  wire logic [15:0] DIG_FREQ,
  input  wire logic [15:0] VOLT_FREQ,
  input  wire logic [15:0] NET_FREQ,
  input  wire logic [7:0]  POT_PCT,
  input  wire logic [7:0]  CUR_PCT,
  input  wire logic [15:0] BASE_FREQ,
  // Offset request terminal, asynchronous pin
  input  wire logic        OFFSET_REQ,
  // Results
  output logic      [15:0] POT_FREQ,
  output logic      [15:0] CUR_FREQ,
  output logic      [31:0] CALC_RESULT,
  output logic      [15:0] OUT_FREQ,
  output logic             OFFSET_ACTIVE
);

  // ==========================================================================
  // State
  logic [15:0] cfg_r    [ISC_NREG];
  logic [15:0] cfg_nxt  [ISC_NREG];
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;
  logic        pready_r;
  logic        pready_nxt;
  logic        pslverr_r;
  logic        pslverr_nxt;
  logic        ofs_s1_r;
  logic        ofs_s1_nxt;
  logic        ofs_s2_r;
  logic        ofs_s2_nxt;
  logic [15:0] pot_freq_r;
  logic [15:0] pot_freq_nxt;
  logic [15:0] cur_freq_r;
  logic [15:0] cur_freq_nxt;
  logic [31:0] calc_r;
  logic [31:0] calc_nxt;
  logic [15:0] out_freq_r;
  logic [15:0] out_freq_nxt;

  // ==========================================================================
  // Helpers

  // Percent to frequency; a point at or above both the start and the end gives the end frequency.
  // A zero-width span (end not above start) acts as a step, avoiding a divide by zero.
  function automatic logic [15:0] map_freq(
    input logic [7:0]  pct,
    input logic [15:0] s_pct,
    input logic [15:0] e_pct,
    input logic [15:0] s_frq,
    input logic [15:0] e_frq,
    input logic        below_zero
  );
    logic signed [31:0] span_f;
    logic signed [31:0] span_p;
    logic signed [31:0] pos;
    logic signed [31:0] val;
    span_f = $signed({16'h0000, e_frq}) - $signed({16'h0000, s_frq});
    span_p = $signed({16'h0000, e_pct}) - $signed({16'h0000, s_pct});
    pos    = $signed({24'h0000_00, pct}) - $signed({16'h0000, s_pct});
    if ({8'h00, pct} < s_pct)
      map_freq = below_zero ? 16'h0000 : s_frq;
    else if ({8'h00, pct} >= e_pct)
      map_freq = e_frq;
    else
    begin
      val = $signed({16'h0000, s_frq}) + (span_f * pos) / span_p;
      map_freq = val[15:0];
    end
  endfunction : map_freq

  function automatic logic [15:0] pick_src(
    input logic [15:0] code,
    input logic [15:0] dig,
    input logic [15:0] pot,
    input logic [15:0] volt,
    input logic [15:0] cur,
    input logic [15:0] net
  );
    case (code)
      ISC_SRC_DIGITAL: pick_src = dig;
      ISC_SRC_POT:     pick_src = pot;
      ISC_SRC_VOLT:    pick_src = volt;
      ISC_SRC_CURRENT: pick_src = cur;
      ISC_SRC_NETWORK: pick_src = net;
      default:         pick_src = dig;
    endcase
  endfunction : pick_src

  // ==========================================================================
  // APB decode
  logic        acc;
  logic        hit_cfg;
  logic [3:0]  slot;
  logic        hit_calc;
  logic        hit_freq;
  logic [15:0] wr_val;
  logic [15:0] cur_val;

  always_comb
  begin
    acc      = PSEL & PENABLE;
    hit_cfg  = 1'b0;
    slot     = 4'h0;
    for (int i = 0; i < ISC_NREG; i++)
    begin
      if (PADDR == {ISC_IDX_TAB[i][13:0], 2'b00})
      begin
        hit_cfg = 1'b1;
        slot    = 4'(i);
      end
    end
    hit_calc = (PADDR == {ISC_STAT_CALC_IDX[13:0], 2'b00});
    hit_freq = (PADDR == {ISC_STAT_FREQ_IDX[13:0], 2'b00});
    cur_val  = cfg_r[slot];
    wr_val[7:0]  = PSTRB[0] ? PWDATA[7:0]  : cur_val[7:0];
    wr_val[15:8] = PSTRB[1] ? PWDATA[15:8] : cur_val[15:8];
  end

  // ==========================================================================
  // Bus next state: one wait cycle, answer registered, write at the ready edge
  always_comb
  begin
    pready_nxt  = acc & ~pready_r;
    prdata_nxt  = 32'h0000_0000;
    pslverr_nxt = 1'b0;
    for (int i = 0; i < ISC_NREG; i++)
      cfg_nxt[i] = cfg_r[i];
    if (acc & ~pready_r)
    begin
      if (PWRITE)
        pslverr_nxt = ~hit_cfg | (wr_val > ISC_MAX_TAB[slot]);
      else if (hit_cfg)
        prdata_nxt = {16'h0000, cur_val};
      else if (hit_calc)
        prdata_nxt = calc_r;
      else if (hit_freq)
        prdata_nxt = {15'h0000, ofs_s2_r, out_freq_r};
      else
        pslverr_nxt = 1'b1;
    end
    // Range check bounds every field: percent, codes and frequencies
    if (acc & pready_r & PWRITE & hit_cfg & (wr_val <= ISC_MAX_TAB[slot]))
      cfg_nxt[slot] = wr_val;
  end

  always_ff @(posedge MCLK)
  begin
    if (SYS_RST)
    begin
      for (int i = 0; i < ISC_NREG; i++)
        cfg_r[i] <= ISC_RST_TAB[i];
      prdata_r  <= 32'h0000_0000;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
    end
    else
    begin
      for (int i = 0; i < ISC_NREG; i++)
        cfg_r[i] <= cfg_nxt[i];
      prdata_r  <= prdata_nxt;
      pready_r  <= pready_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  // ==========================================================================
  // Datapath next state
  logic [15:0] opa;
  logic [15:0] opb;
  logic [16:0] ofs_sum;

  always_comb
  begin
    ofs_s1_nxt = OFFSET_REQ;
    ofs_s2_nxt = ofs_s1_r;
    pot_freq_nxt = map_freq(POT_PCT, cfg_r[ISC_S_POT_SP], cfg_r[ISC_S_POT_EP],
                            cfg_r[ISC_S_POT_SF], cfg_r[ISC_S_POT_EF],
                            cfg_r[ISC_S_POT_EN] != ISC_POT_EN_ON);
    cur_freq_nxt = map_freq(CUR_PCT, cfg_r[ISC_S_CUR_SP], cfg_r[ISC_S_CUR_EP],
                            cfg_r[ISC_S_CUR_SF], cfg_r[ISC_S_CUR_EF],
                            cfg_r[ISC_S_CUR_SEL] != ISC_CUR_SEL_CFG);
    opa = pick_src(cfg_r[ISC_S_OPA], DIG_FREQ, pot_freq_r, VOLT_FREQ,
                   cur_freq_r, NET_FREQ);
    opb = pick_src(cfg_r[ISC_S_OPB], DIG_FREQ, pot_freq_r, VOLT_FREQ,
                   cur_freq_r, NET_FREQ);
    case (cfg_r[ISC_S_OPER])
      ISC_OPER_ADD: calc_nxt = {16'h0000, opa} + {16'h0000, opb};
      ISC_OPER_SUB: calc_nxt = {16'h0000, opa} - {16'h0000, opb};
      ISC_OPER_MUL: calc_nxt = opa * opb;
      default:      calc_nxt = {16'h0000, opa} + {16'h0000, opb};
    endcase
    // Offset result clamps to 0..max so a minus offset never wraps
    out_freq_nxt = BASE_FREQ;
    ofs_sum      = {1'b0, BASE_FREQ} + {1'b0, cfg_r[ISC_S_OFS]};
    if (ofs_s2_r)
    begin
      if (cfg_r[ISC_S_SIGN] == ISC_SIGN_PLUS)
        out_freq_nxt = (ofs_sum > {1'b0, ISC_FREQ_MAX}) ? ISC_FREQ_MAX : ofs_sum[15:0];
      else if (BASE_FREQ > cfg_r[ISC_S_OFS])
        out_freq_nxt = BASE_FREQ - cfg_r[ISC_S_OFS];
      else
        out_freq_nxt = 16'h0000;
    end
  end

  always_ff @(posedge MCLK)
  begin
    if (SYS_RST)
    begin
      ofs_s1_r   <= 1'b0;
      ofs_s2_r   <= 1'b0;
      pot_freq_r <= 16'h0000;
      cur_freq_r <= 16'h0000;
      calc_r     <= 32'h0000_0000;
      out_freq_r <= 16'h0000;
    end
    else
    begin
      ofs_s1_r   <= ofs_s1_nxt;
      ofs_s2_r   <= ofs_s2_nxt;
      pot_freq_r <= pot_freq_nxt;
      cur_freq_r <= cur_freq_nxt;
      calc_r     <= calc_nxt;
      out_freq_r <= out_freq_nxt;
    end
  end

  // ==========================================================================
  // Outputs
  assign PRDATA        = prdata_r;
  assign PREADY        = pready_r;
  assign PSLVERR       = pslverr_r;
  assign POT_FREQ      = pot_freq_r;
  assign CUR_FREQ      = cur_freq_r;
  assign CALC_RESULT   = calc_r;
  assign OUT_FREQ      = out_freq_r;
  assign OFFSET_ACTIVE = ofs_s2_r;

endmodule : isc_bank

// ===== sim/isc_props.sv
/*
  Checker for the register bank: APB answer timing, refusals, offset path.
  Assumes a bind to isc_bank, one clock domain, synchronous reset.
*/
`timescale 1ns/1ps
module isc_props
  import isc_pkg::*;
(
  // Clock and reset
  input wire logic        MCLK,
  input wire logic        SYS_RST,
  // APB
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [15:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [3:0]  PSTRB,
  input wire logic [31:0] PRDATA,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  // Offset path
  input wire logic [15:0] BASE_FREQ,
  input wire logic        OFFSET_REQ,
  input wire logic [15:0] OUT_FREQ,
  input wire logic        OFFSET_ACTIVE
);
  // ==========================================================================
  // Sequences and properties
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (SYS_RST);
  sequence s_setup;
    PSEL && !PENABLE;
  endsequence
  sequence s_answer;
    !PREADY ##1 PREADY;
  endsequence
  // Full-word write above the field maximum must come back refused
  property p_rej(logic [15:0] idx, logic [15:0] mx);
    s_setup ##0 (PWRITE && PADDR == {idx[13:0], 2'b00} && PSTRB == 4'hF
      && PWDATA[15:0] > mx) |=> s_answer ##0 PSLVERR;
  endproperty
  // ==========================================================================
  // Assertions
  AST_RDY_WAIT: assert property (s_setup |=> s_answer)
    else $error("answer not after one wait state");
  AST_RDY_PULSE: assert property (PREADY |=> !PREADY)
    else $error("ready longer than one cycle");
  AST_ALIGN: assert property (s_setup ##0 PADDR[1:0] != 2'b00 |=> s_answer ##0 PSLVERR)
    else $error("misaligned access not refused");
  AST_ERR_ZERO: assert property (PREADY && PSLVERR |-> PRDATA == 32'h0000_0000)
    else $error("refused access returned data");
  AST_REJ_OPA: assert property (p_rej(ISC_OPA_SRC_IDX, ISC_SRC_MAX))
    else $error("bad operand A code accepted");
  AST_REJ_OPB: assert property (p_rej(ISC_OPB_SRC_IDX, ISC_SRC_MAX))
    else $error("bad operand B code accepted");
  AST_REJ_OPER: assert property (p_rej(ISC_OPERATOR_IDX, ISC_OP_MAX))
    else $error("bad operator code accepted");
  AST_REJ_SIGN: assert property (p_rej(ISC_OFS_SIGN_IDX, ISC_BIT_MAX))
    else $error("bad sign code accepted");
  AST_REJ_EN: assert property (p_rej(ISC_POT_START_EN_IDX, ISC_BIT_MAX))
    else $error("bad enable code accepted");
  AST_OFS_ON: assert property (OFFSET_REQ [*3] |-> OFFSET_ACTIVE)
    else $error("offset request not seen in time");
  AST_OFS_OFF: assert property (!OFFSET_REQ [*3] |-> !OFFSET_ACTIVE)
    else $error("offset active without request");
  AST_OUT_PASS: assert property (!OFFSET_ACTIVE |=> OUT_FREQ == $past(BASE_FREQ))
    else $error("output altered without offset");
endmodule : isc_props

// ===== sim/isc_apb_master.sv
/*
  Network master model: full-word APB reads and writes on request.
  Assumes tasks are entered just after a rising edge of clk.
*/
`timescale 1ns/1ps
module isc_apb_master
(
  // Clock
  input wire logic        clk,
  // APB request
  output logic            psel,
  output logic            penable,
  output logic            pwrite,
  output logic     [15:0] paddr,
  output logic     [31:0] pwdata,
  output logic     [3:0]  pstrb,
  // APB answer
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr
);
  initial
  begin
    psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0; pstrb = 4'hF;
  end
  // Request held until ready or 20 cycles; released address and data show inverted values, not stale ones
  task automatic xfer(input logic w, input logic [15:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e, output logic t);
    int n;
    n = 0;
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    q = prdata;
    e = pslverr;
    t = (pready !== 1'b1);
    psel <= 0; penable <= 0; paddr <= ~a; pwdata <= ~d;
    @(posedge clk);
  endtask : xfer
endmodule : isc_apb_master

// ===== sim/isc_bank_tb.sv
/*
  Self-checking bench: register hold and refusal, mapping, calculate, offset.
  Assumes isc_apb_master as the network master and isc_props bound below.
*/
`timescale 1ns/1ps
module isc_bank_tb
  import isc_pkg::*;
;
  logic        MCLK, SYS_RST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, OFFSET_REQ, OFFSET_ACTIVE;
  logic [15:0] PADDR, DIG_FREQ, VOLT_FREQ, NET_FREQ, BASE_FREQ, POT_FREQ, CUR_FREQ, OUT_FREQ;
  logic [31:0] PWDATA, PRDATA, CALC_RESULT, q, ex;
  logic [7:0]  POT_PCT, CUR_PCT;
  logic [3:0]  PSTRB;
  logic [15:0] v, b, o;
  int          failures, n_tests;
  isc_bank i_dut (.MCLK(MCLK), .SYS_RST(SYS_RST), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .DIG_FREQ(DIG_FREQ), .VOLT_FREQ(VOLT_FREQ),
    .NET_FREQ(NET_FREQ), .POT_PCT(POT_PCT), .CUR_PCT(CUR_PCT), .BASE_FREQ(BASE_FREQ),
    .OFFSET_REQ(OFFSET_REQ), .POT_FREQ(POT_FREQ), .CUR_FREQ(CUR_FREQ),
    .CALC_RESULT(CALC_RESULT), .OUT_FREQ(OUT_FREQ), .OFFSET_ACTIVE(OFFSET_ACTIVE));
  isc_apb_master i_mst (.clk(MCLK), .psel(PSEL), .penable(PENABLE), .pwrite(PWRITE),
    .paddr(PADDR), .pwdata(PWDATA), .pstrb(PSTRB), .prdata(PRDATA), .pready(PREADY),
    .pslverr(PSLVERR));
  // ==========================================================================
  // Checking and bus tasks
  task automatic tally_and_finish;
    if (failures == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      failures++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [15:0] a, input logic [31:0] d,
                     input logic xe);
    logic e, t;
    i_mst.xfer(w, a, d, q, e, t);
    if (t)
    begin
      failures++;
      tally_and_finish();
    end
    chk({31'h0, e}, {31'h0, xe});
  endtask : bus
  // ==========================================================================
  // Expectations
  function automatic logic [15:0] fmap(logic [7:0] p, int s, int e, int sf, int ef, logic z);
    if (p < s) return z ? 16'h0000 : 16'(sf);
    if (p >= e) return 16'(ef);
    return 16'(sf + ((ef - sf) * (int'(p) - s)) / (e - s));
  endfunction : fmap
  function automatic logic [31:0] src(int c);
    case (c)
      0: return {16'h0, DIG_FREQ};
      1: return {16'h0, fmap(POT_PCT, 10, 60, 100, 1100, 0)};
      2: return {16'h0, VOLT_FREQ};
      3: return {16'h0, fmap(CUR_PCT, 20, 70, 200, 2200, 0)};
      default: return {16'h0, NET_FREQ};
    endcase
  endfunction : src
  // ==========================================================================
  // Stimulus
  initial
  begin
    MCLK = 0;
    forever #25 MCLK = ~MCLK;
  end
  initial
  begin
    failures = 0; n_tests = 0; SYS_RST = 1; OFFSET_REQ = 0; BASE_FREQ = 0;
    DIG_FREQ = 0; VOLT_FREQ = 0; NET_FREQ = 0; POT_PCT = 0; CUR_PCT = 0;
    void'($urandom(32'h6ac0));
    repeat (20) @(posedge MCLK);
    SYS_RST <= 0;
    for (int i = 0; i < ISC_NREG; i++)
    begin
      bus(0, {ISC_IDX_TAB[i][13:0], 2'b00}, 0, 0);
      chk(q, {16'h0, ISC_RST_TAB[i]});
      v = 16'($urandom_range(int'(ISC_MAX_TAB[i])));
      bus(1, {ISC_IDX_TAB[i][13:0], 2'b00}, {16'h0, v}, 0);
      bus(1, {ISC_IDX_TAB[i][13:0], 2'b00}, {16'h0, ISC_MAX_TAB[i] + 16'h1}, 1);
      bus(0, {ISC_IDX_TAB[i][13:0], 2'b00}, 0, 0);
      chk(q, {16'h0, v});
    end
    bus(0, 16'h4204, 0, 1);
    bus(0, 16'h420E, 0, 1);
    for (int k = 0; k < ISC_NREG; k++)
      bus(1, {ISC_IDX_TAB[k][13:0], 2'b00}, 0, 0);
    // Mapping registers: pot 10..60 pct to 100..1100, current 20..70 pct to 200..2200
    bus(1, 16'h4200, 200, 0); bus(1, 16'h4208, 2200, 0); bus(1, 16'h420C, 20, 0);
    bus(1, 16'h4210, 70, 0); bus(1, 16'h4254, 100, 0); bus(1, 16'h425C, 1100, 0);
    bus(1, 16'h4260, 10, 0); bus(1, 16'h4264, 60, 0);
    for (int k = 0; k < 8; k++)
    begin
      bus(1, 16'h4268, k % 2, 0);
      bus(1, 16'h4214, k % 2, 0);
      POT_PCT <= k == 0 ? 8'd9 : k == 1 ? 8'd60 : 8'($urandom_range(100));
      CUR_PCT <= k == 0 ? 8'd19 : k == 1 ? 8'd70 : 8'($urandom_range(100));
      repeat (2) @(posedge MCLK);
      chk(POT_FREQ, fmap(POT_PCT, 10, 60, 100, 1100, k % 2 == 0));
      chk(CUR_FREQ, fmap(CUR_PCT, 20, 70, 200, 2200, k % 2 == 1));
    end
    bus(1, 16'h4214, 0, 0);
    DIG_FREQ <= 16'($urandom_range(4000)); VOLT_FREQ <= 16'($urandom_range(4000));
    NET_FREQ <= 16'($urandom_range(4000));
    for (int op = 0; op < 3; op++)
      for (int a = 0; a < 5; a++)
      begin
        bus(1, 16'h4240, op, 0); bus(1, 16'h4238, a, 0); bus(1, 16'h423C, 4 - a, 0);
        repeat (3) @(posedge MCLK);
        ex = op == 0 ? src(a) + src(4 - a) : op == 1 ? src(a) - src(4 - a) : src(a) * src(4 - a);
        chk(CALC_RESULT, ex);
        bus(0, {ISC_STAT_CALC_IDX[13:0], 2'b00}, 0, 0);
        chk(q, ex);
      end
    bus(1, {ISC_STAT_CALC_IDX[13:0], 2'b00}, 0, 1);
    for (int k = 0; k < 6; k++)
    begin
      b = k == 0 ? 16'd3900 : k == 1 ? 16'd100 : 16'($urandom_range(4000));
      o = k < 2 ? 16'd500 : 16'($urandom_range(4000));
      bus(1, 16'h4244, o, 0); bus(1, 16'h424C, k % 2, 0);
      BASE_FREQ <= b; OFFSET_REQ <= 1;
      repeat (4) @(posedge MCLK);
      ex = k % 2 == 0 ? (b + o > 4000 ? 4000 : b + o) : (b > o ? b - o : 0);
      chk(OUT_FREQ, ex);
      bus(0, {ISC_STAT_FREQ_IDX[13:0], 2'b00}, 0, 0);
      chk(q, {15'h0, 1'b1, ex[15:0]});
      OFFSET_REQ <= 0;
      repeat (4) @(posedge MCLK);
      chk(OUT_FREQ, b);
    end
    tally_and_finish();
  end
endmodule : isc_bank_tb

bind isc_bank isc_props i_props (.MCLK(MCLK), .SYS_RST(SYS_RST), .PSEL(PSEL),
  .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB),
  .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .BASE_FREQ(BASE_FREQ),
  .OFFSET_REQ(OFFSET_REQ), .OUT_FREQ(OUT_FREQ), .OFFSET_ACTIVE(OFFSET_ACTIVE));
